// ### far_side_model.sv
// Model of the DMA, transfer and converter side facing the block.
`timescale 1ns/1ns
`default_nettype none
module far_side_model (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        slow_i,
	input  wire logic [1:0]  sel_i,
	input  wire logic [19:0] xfer_req_i,
	input  wire logic [4:0]  dma_req_i,
	input  wire logic [3:0]  adc_req_i,
	output var  logic [19:0] xfer_ack_o,
	output var  logic [4:0]  dma_ack_o,
	output var  logic [7:0]  starts_o
);
	logic [24:0] held;
	// ----------------------------------------------------------------
	// Engines
	// ----------------------------------------------------------------
	// A slow engine acks a cycle later, so the flag lingers longer.
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			held <= 25'h0;
			{xfer_ack_o, dma_ack_o} <= 25'h0;
			starts_o <= 8'h0;
		end else begin
			held <= slow_i ? {xfer_req_i, dma_req_i} : 25'h0;
			{xfer_ack_o, dma_ack_o} <= slow_i ? held : {xfer_req_i, dma_req_i};
			if (adc_req_i[sel_i])
				starts_o <= starts_o + 8'h1;
		end
	end
	// Priority between channels is left to the controller.
endmodule // far_side_model
`default_nettype wire

// ### testbench.sv
// Self-checking testbench for the timer event and request logic.
`timescale 1ns/1ns
`default_nettype none
`include "timer_event_request_consts.vh"
module testbench;
	logic        clk_i = 1'b0, rst_n_i = 1'b0, slow = 1'b0;
	logic [7:0]  s_axi_awaddr_i = 8'h0, s_axi_araddr_i = 8'h0;
	logic [31:0] s_axi_wdata_i = 32'h0;
	logic [3:0]  s_axi_wstrb_i = 4'hf;
	logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
	logic        s_axi_bready_i = 1'b0, s_axi_arvalid_i = 1'b0;
	logic        s_axi_rready_i = 1'b0, ch4_count_up_i = 1'b0;
	logic [20:0] match_event_i = 21'h0, capture_event_i = 21'h0;
	logic [4:0]  overflow_event_i = 5'h0;
	logic [1:0]  underflow_event_i = 2'h0, sel = 2'h0;
	logic [15:0] ch4_counter_i = 16'h0;
	logic        comp_pwm_i = 1'b0, crest_i = 1'b0, trough_i = 1'b0;
	logic [2:0]  pw_line_i = 3'h0;
	wire logic [19:0] xfer_ack_i, xfer_req_o;
	wire logic [4:0]  dma_ack_i, dma_req_o, counter_start_o;
	wire logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, companion_start_o;
	wire logic [31:0] s_axi_rdata_o;
	wire logic [27:0] irq_o;
	wire logic [7:0]  starts;
	wire logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
	wire logic        s_axi_arready_o, s_axi_rvalid_o, companion_clear_o;
	wire logic        common_adc_start_request_o, ch0_compare_adc_start_request_o;
	wire logic        delayed_adc_start_request_a_o, delayed_adc_start_request_b_o;
	int          num_errors = 0, n_compared = 0, cycles = 0;
	int          n_dma = 0, n_xfer = 0, n_clr = 0;

	timer_event_request_logic i_dut (.*);
	far_side_model i_far (.clk_i, .rst_n_i, .slow_i(slow), .sel_i(sel),
		.xfer_req_i(xfer_req_o), .dma_req_i(dma_req_o),
		.adc_req_i({delayed_adc_start_request_b_o, delayed_adc_start_request_a_o,
			ch0_compare_adc_start_request_o, common_adc_start_request_o}),
		.xfer_ack_o(xfer_ack_i), .dma_ack_o(dma_ack_i), .starts_o(starts));

	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cycles++;
		n_dma += (dma_req_o[0] === 1'b1);
		n_xfer += (xfer_req_o[0] === 1'b1);
		n_clr += (companion_clear_o === 1'b1);
		if (cycles == 20000) begin
			num_errors++;
			final_report();
		end
	end
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic ok, input string what);
		n_compared++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("Error at %0t: %s", $time, what);
		end
	endtask
	task automatic final_report;
		$display("Compared %0d, errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw, w;
		@(posedge clk_i);
		aw = 1'b1;
		w = 1'b1;
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		while (aw || w) begin
			@(posedge clk_i);
			if (aw && s_axi_awready_o) begin
				aw = 1'b0;
				s_axi_awvalid_i <= 1'b0;
			end
			if (w && s_axi_wready_o) begin
				w = 1'b0;
				s_axi_wvalid_i <= 1'b0;
			end
		end
		do @(posedge clk_i); while (s_axi_bvalid_o !== 1'b1);
		r = s_axi_bresp_o;
		s_axi_bready_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_i);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		do @(posedge clk_i); while (s_axi_arready_o !== 1'b1);
		s_axi_arvalid_i <= 1'b0;
		do @(posedge clk_i); while (s_axi_rvalid_o !== 1'b1);
		d = s_axi_rdata_o;
		r = s_axi_rresp_o;
		s_axi_rready_i <= 1'b0;
	endtask
	task automatic pulse(input logic [20:0] m, input logic [20:0] c, input logic [6:0] ou);
		@(posedge clk_i);
		match_event_i <= m;
		capture_event_i <= c;
		{underflow_event_i, overflow_event_i} <= ou;
		@(posedge clk_i);
		match_event_i <= 21'h0;
		capture_event_i <= 21'h0;
		{underflow_event_i, overflow_event_i} <= 7'h0;
		repeat (6) @(posedge clk_i);
		#1;
	endtask
	task automatic ramp(input logic up);
		for (int i = 0; i < 32; i++) begin
			@(posedge clk_i);
			ch4_count_up_i <= up;
			ch4_counter_i <= up ? 16'(i) : 16'(31 - i);
		end
		repeat (4) @(posedge clk_i);
	endtask
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Capture never sets the fifth and sixth channel 0 flags.
	function automatic logic [27:0] exp_of(input logic [20:0] m, input logic [20:0] c, input logic [6:0] ou);
		return {ou, m | (c & ~21'h30)};
	endfunction
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] d, a, b, s;
		logic [1:0]  r;
		logic [27:0] acc;
		s = 32'd90;
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rd(`OFS_FLAGS, d, r);
		chk(d === 32'h0 && r === `RESP_OKAY, "flags after reset");
		rd(8'hfc, d, r);
		chk(r === `RESP_SLVERR, "unmapped read");
		wr(`OFS_CAPTURE, 32'h1, r);
		chk(r === `RESP_SLVERR, "read-only write");
		wr(`OFS_IRQ_ENABLE, 32'h0fff_ffff, r);
		for (int k = 0; k < 8; k++) begin
			a = (k == 0) ? 32'hffff_ffff : lfsr(s);
			b = (k == 0) ? 32'hffff_ffff : lfsr(a);
			s = b;
			pulse(a[20:0], {a[31:21], b[9:0]}, b[16:10]);
			acc = exp_of(a[20:0], {a[31:21], b[9:0]}, b[16:10]);
			chk(irq_o === acc, "interrupt lines");
			rd(`OFS_FLAGS, d, r);
			chk(d[27:0] === acc, "flag readback");
			wr(`OFS_FLAGS, 32'h0, r);
			#1 chk(irq_o === 28'h0, "software clear");
		end
		slow = 1'b1;
		wr(`OFS_XFER_ENABLE, 32'h0100_0001, r);
		pulse(21'h1, 21'h0, 7'h0);
		chk(irq_o[0] === 1'b0 && n_dma == 1 && n_xfer == 1, "slow ack");
		slow = 1'b0;
		pulse(21'h0, 21'h1, 7'h0);
		chk(irq_o[0] === 1'b0 && n_dma == 2, "prompt ack");
		wr(`OFS_ADC_CONTROL, 32'h1, r);
		pulse(21'h41, 21'h0, 7'h0);
		chk(starts === 8'd1, "first flag start");
		sel = 2'd1;
		wr(`OFS_ADC_CONTROL, 32'h40, r);
		pulse(21'h0, 21'h10, 7'h0);
		pulse(21'h10, 21'h0, 7'h0);
		chk(starts === 8'd2, "fifth match start");
		sel = 2'd2;
		wr(`OFS_CYCLE_SET_A, 32'h10, r);
		wr(`OFS_ADC_CONTROL, 32'h80, r);
		ramp(1'b1);
		chk(starts === 8'd3, "delayed start");
		sel <= 2'd0;
		comp_pwm_i <= 1'b1;
		wr(`OFS_ADC_CONTROL, 32'h20, r);
		ramp(1'b0);
		chk(starts === 8'd4, "trough start");
		wr(`OFS_SYNC_START, 32'h7f, r);
		#1 chk(counter_start_o === 5'h1f && companion_start_o === 2'h3, "sync start");
		wr(`OFS_SYNC_CLEAR, 32'h1, r);
		pulse(21'h2, 21'h0, 7'h0);
		pulse(21'h1, 21'h0, 7'h0);
		chk(n_clr == 1, "companion clear");
		wr(`OFS_IO_CONTROL, 32'h1, r);
		@(posedge clk_i);
		ch4_counter_i <= 16'h1234;
		crest_i <= 1'b1;
		@(posedge clk_i);
		crest_i <= 1'b0;
		rd(`OFS_CAPTURE, d, r);
		chk(d[15:0] === 16'h1234, "crest capture");
		wr(`OFS_IO_CONTROL, 32'h6, r);
		@(posedge clk_i);
		ch4_counter_i <= 16'h0;
		trough_i <= 1'b1;
		pw_line_i <= 3'h1;
		@(posedge clk_i);
		trough_i <= 1'b0;
		repeat (9) @(posedge clk_i);
		pw_line_i <= 3'h0;
		repeat (4) @(posedge clk_i);
		rd(`OFS_CAPTURE, d, r);
		chk(d[15:0] === 16'h0 && starts === 8'd5, "trough capture");
		rd(`OFS_WIDTH_0, d, r);
		chk(d[15:0] === 16'd10 && irq_o[18] === 1'b1, "pulse width");
		wr(`OFS_FLAGS, 32'h0, r);
		#1 chk(irq_o[6] === 1'b1 && irq_o[18] === 1'b1, "unread kept");
		sel <= 2'd3;
		wr(`OFS_CYCLE_SET_B, 32'h8, r);
		wr(`OFS_ADC_CONTROL, 32'h400, r);
		ramp(1'b0);
		chk(starts === 8'd6, "delayed start b");
		final_report();
	end
endmodule // testbench
`default_nettype wire

// ### timer_event_request_chk.sv
// Port checker for the timer event and request logic.
`timescale 1ns/1ns
`default_nettype none
module timer_event_request_chk (
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	input wire logic        s_axi_wvalid_i,
	input wire logic        s_axi_bready_i,
	input wire logic        s_axi_bvalid_o,
	input wire logic [20:0] match_event_i,
	input wire logic [20:0] capture_event_i,
	input wire logic [15:0] ch4_counter_i,
	input wire logic        trough_i,
	input wire logic [19:0] xfer_ack_i,
	input wire logic [4:0]  dma_ack_i,
	input wire logic [4:0]  counter_start_o,
	input wire logic        companion_clear_o,
	input wire logic [27:0] irq_o,
	input wire logic [19:0] xfer_req_o,
	input wire logic [4:0]  dma_req_o,
	input wire logic        common_adc_start_request_o,
	input wire logic        ch0_compare_adc_start_request_o,
	input wire logic        delayed_adc_start_request_a_o
);
	wire logic [20:0] ev;
	assign ev = match_event_i | capture_event_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// ----------------------------------------------------------------
	// Requests follow their causes
	// ----------------------------------------------------------------
	a_dma_cause: assert property (dma_req_o[0] |-> $past(ev[0]))
		else $error("dma request without event");
	a_xfer_cause: assert property (xfer_req_o[0] |-> $past(ev[0]))
		else $error("transfer request without event");
	a_adc_cause: assert property (common_adc_start_request_o |->
		$past(ev[0] | ev[6] | ev[8] | ev[10] | ev[14] | trough_i) ||
		$past(ch4_counter_i) == 16'h0 || $past(ch4_counter_i, 2) == 16'h0)
		else $error("common start without cause");
	a_fifth_match: assert property (ch0_compare_adc_start_request_o |->
		$past(match_event_i[4])) else $error("fifth start without match");
	a_delay_pulse: assert property (delayed_adc_start_request_a_o |=>
		!delayed_adc_start_request_a_o) else $error("delayed start too long");
	a_clear_cause: assert property (companion_clear_o |->
		$past(|{ev[9:6], ev[3:0]})) else $error("companion clear uncaused");
	// ----------------------------------------------------------------
	// Flags, starts and bus
	// ----------------------------------------------------------------
	a_flag_hold: assert property (irq_o[0] && !s_axi_wvalid_i &&
		!$past(s_axi_wvalid_i) && !xfer_ack_i[0] && !dma_ack_i[0] |=> irq_o[0])
		else $error("flag lost");
	a_ack_clear: assert property (dma_ack_i[0] && !ev[0] |=> !irq_o[0])
		else $error("flag kept after ack");
	a_start_write: assert property ($changed(counter_start_o) |->
		$past(s_axi_wvalid_i) || $past(s_axi_wvalid_i, 2))
		else $error("start changed without write");
	a_resp_stands: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
		s_axi_bvalid_o) else $error("write response dropped");
endmodule // timer_event_request_chk
bind timer_event_request_logic timer_event_request_chk i_chk (.*);
`default_nettype wire

// ### timer_event_request_consts.vh
// Constants for the timer event and request logic.
// Functional notes
// - One write starts own and companion counters.
// - Selected channel 0-2 flag events clear companion.
// - Channel 5 measures three input pulse widths.
// - Width measurement also serves dead time compensation.
// - Crest or trough capture into capture register.
// - Match, overflow, underflow flags with own enables.
// - Flag set on event; request while enabled.
// - Fixed in-channel order; controller orders channels.
// - Twenty-one match/capture flags across six channels.
// - Channel 0 fifth, sixth flags: match only.
// - Five overflow flags with overflow requests.
// - Underflow flags only on channels 1 and 2.
// - Twenty transfer controller activation sources.
// - Five DMA activation sources, first flags.
// - First flag plus enable issues common start.
// - Channel 4 trough also issues common start.
// - Channel 0 fifth match issues dedicated start.
// - Counter equals cycle set issues delayed start.
// - Clear flag by writing zero after reading one.
// - Transfer or DMA activation clears its flag.
`ifndef TIMER_EVENT_REQUEST_CONSTS_VH
`define TIMER_EVENT_REQUEST_CONSTS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_SYNC_START    8'h00
`define OFS_SYNC_CLEAR    8'h04
`define OFS_FLAGS         8'h08
`define OFS_IRQ_ENABLE    8'h0c
`define OFS_ADC_CONTROL   8'h10
`define OFS_XFER_ENABLE   8'h14
`define OFS_IO_CONTROL    8'h18
`define OFS_CAPTURE       8'h1c
`define OFS_CYCLE_SET_A   8'h20
`define OFS_CYCLE_SET_B   8'h24
`define OFS_WIDTH_0       8'h28
`define OFS_WIDTH_1       8'h2c
`define OFS_WIDTH_2       8'h30

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define FLAG_OVF_LSB      21
`define FLAG_UNF_LSB      26
`define FLAG_CH0_FIFTH    4
`define FLAG_CH0_SIXTH    5
`define FLAG_CH5_LSB      18
`define ADC_TROUGH_EN     5
`define ADC_SECOND_EN     6
`define ADC_UP_A          7
`define ADC_DOWN_A        8
`define ADC_UP_B          9
`define ADC_DOWN_B        10
`define XFER_DMA_LSB      24
`define IO_PW_EN_LSB      2
`define IO_PW_LOW         5

// ----------------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------------
`define RST_ZERO32        32'h0000_0000
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// ### timer_event_request_logic.v
// Event, flag and request logic of a six-channel motor-control timer.
`timescale 1ns/1ns
`default_nettype none
`include "timer_event_request_consts.vh"

module timer_event_request_logic (
	input  wire        clk_i,
	input  wire        rst_n_i,
	input  wire [7:0]  s_axi_awaddr_i,
	input  wire        s_axi_awvalid_i,
	output wire        s_axi_awready_o,
	input  wire [31:0] s_axi_wdata_i,
	input  wire [3:0]  s_axi_wstrb_i,
	input  wire        s_axi_wvalid_i,
	output wire        s_axi_wready_o,
	output reg  [1:0]  s_axi_bresp_o,
	output reg         s_axi_bvalid_o,
	input  wire        s_axi_bready_i,
	input  wire [7:0]  s_axi_araddr_i,
	input  wire        s_axi_arvalid_i,
	output wire        s_axi_arready_o,
	output reg  [31:0] s_axi_rdata_o,
	output reg  [1:0]  s_axi_rresp_o,
	output reg         s_axi_rvalid_o,
	input  wire        s_axi_rready_i,
	input  wire [20:0] match_event_i,
	input  wire [20:0] capture_event_i,
	input  wire [4:0]  overflow_event_i,
	input  wire [1:0]  underflow_event_i,
	input  wire [15:0] ch4_counter_i,
	input  wire        ch4_count_up_i,
	input  wire        comp_pwm_i,
	input  wire        crest_i,
	input  wire        trough_i,
	input  wire [2:0]  pw_line_i,
	input  wire [19:0] xfer_ack_i,
	input  wire [4:0]  dma_ack_i,
	output reg  [4:0]  counter_start_o,
	output reg  [1:0]  companion_start_o,
	output reg         companion_clear_o,
	output wire [27:0] irq_o,
	output reg  [19:0] xfer_req_o,
	output reg  [4:0]  dma_req_o,
	output reg         common_adc_start_request_o,
	output reg         ch0_compare_adc_start_request_o,
	output reg         delayed_adc_start_request_a_o,
	output reg         delayed_adc_start_request_b_o
);

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function [31:0] merge;
		input [31:0] old;
		input [31:0] data;
		input [3:0]  strb;
		integer      k;
		begin
			merge = old;
			for (k = 0; k < 4; k = k + 1) begin
				if (strb[k]) begin
					merge[k*8 +: 8] = data[k*8 +: 8];
				end
			end
		end
	endfunction

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	reg        aw_held;
	reg [7:0]  aw_addr;
	reg        w_held;
	reg [31:0] w_data;
	reg [3:0]  w_strb;
	reg [7:0]  sync_clear_select;
	reg [27:0] flags;
	reg [27:0] flags_read_one;
	reg [27:0] irq_enable;
	reg [10:0] adc_control;
	reg [19:0] xfer_enable;
	reg [4:0]  dma_enable;
	reg [5:0]  io_control;
	reg [15:0] capture_value;
	reg [15:0] adc_cycle_set_a;
	reg [15:0] adc_cycle_set_b;
	reg [15:0] prev_counter;
	reg [2:0]  pw_meta;
	reg [2:0]  pw_sync;
	reg [2:0]  pw_prev;
	reg [15:0] pw_count [0:2];
	reg [15:0] pw_width [0:2];
	reg [2:0]  pw_done;
	reg [31:0] rd_val;
	reg [31:0] wr_cur;
	reg        rd_ok;
	reg        wr_ok;
	integer    i;

	wire do_wr = aw_held & w_held & ~s_axi_bvalid_o;
	wire do_rd = s_axi_arvalid_i & ~s_axi_rvalid_o;

	assign s_axi_awready_o = ~aw_held & ~s_axi_bvalid_o;
	assign s_axi_wready_o  = ~w_held & ~s_axi_bvalid_o;
	assign s_axi_arready_o = ~s_axi_rvalid_o;

	// ------------------------------------------------------------------
	// Flag set events
	// ------------------------------------------------------------------
	// The two extra channel 0 compare flags ignore capture strobes.
	wire [20:0] cap_ok = capture_event_i &
		~(21'h000001 << `FLAG_CH0_FIFTH) &
		~(21'h000001 << `FLAG_CH0_SIXTH);
	wire [20:0] cm_set = match_event_i | cap_ok |
		({18'h00000, pw_done} << `FLAG_CH5_LSB);
	wire [27:0] set_ev = {underflow_event_i, overflow_event_i,
		cm_set};

	wire [19:0] xsrc_set = {set_ev[20:18], set_ev[25], set_ev[17:6],
		set_ev[3:0]};
	wire [4:0]  dsrc_set = {set_ev[14], set_ev[10], set_ev[8], set_ev[6],
		set_ev[0]};
	wire [4:0]  first_set = dsrc_set;

	// Activation acknowledges map back onto the flags they serve.
	wire [27:0] xack_clr = {2'h0, xfer_ack_i[16], 4'h0, xfer_ack_i[19:17],
		xfer_ack_i[15:4], 2'h0, xfer_ack_i[3:0]};
	wire [27:0] dack_clr = {13'h0000, dma_ack_i[4], 3'h0, dma_ack_i[3],
		1'b0, dma_ack_i[2], 1'b0, dma_ack_i[1], 5'h00, dma_ack_i[0]};

	wire        flag_wr = do_wr && (aw_addr == `OFS_FLAGS);
	wire [31:0] flag_wval = merge({4'h0, flags}, w_data, w_strb);
	wire [27:0] sw_clr = flag_wr ?
		(flags_read_one & ~flag_wval[27:0]) : 28'h0000000;
	wire [27:0] next_flags = (flags & ~sw_clr & ~xack_clr & ~dack_clr) |
		set_ev;

	// Each channel offers its own request lines; ordering between
	// channels is left to the interrupt controller.
	assign irq_o = flags & irq_enable;

	// ------------------------------------------------------------------
	// Conversion start conditions
	// ------------------------------------------------------------------
	wire trough_hit = comp_pwm_i && (ch4_counter_i == 16'h0000) &&
		(prev_counter != 16'h0000);
	wire hit_a = (ch4_counter_i == adc_cycle_set_a) &&
		(prev_counter != adc_cycle_set_a);
	wire hit_b = (ch4_counter_i == adc_cycle_set_b) &&
		(prev_counter != adc_cycle_set_b);
	wire en_a = ch4_count_up_i ? adc_control[`ADC_UP_A] :
		adc_control[`ADC_DOWN_A];
	wire en_b = ch4_count_up_i ? adc_control[`ADC_UP_B] :
		adc_control[`ADC_DOWN_B];
	wire [7:0] clr_src = {set_ev[9:6], set_ev[3:0]};

	// ------------------------------------------------------------------
	// Register read decode
	// ------------------------------------------------------------------
	always @* begin
		rd_val = `RST_ZERO32;
		rd_ok  = 1'b1;
		case (s_axi_araddr_i)
			`OFS_SYNC_START:  rd_val = {25'h0, companion_start_o,
				counter_start_o};
			`OFS_SYNC_CLEAR:  rd_val = {24'h0, sync_clear_select};
			`OFS_FLAGS:       rd_val = {4'h0, flags};
			`OFS_IRQ_ENABLE:  rd_val = {4'h0, irq_enable};
			`OFS_ADC_CONTROL: rd_val = {21'h0, adc_control};
			`OFS_XFER_ENABLE: rd_val = {3'h0, dma_enable, 4'h0,
				xfer_enable};
			`OFS_IO_CONTROL:  rd_val = {26'h0, io_control};
			`OFS_CAPTURE:     rd_val = {16'h0, capture_value};
			`OFS_CYCLE_SET_A: rd_val = {16'h0, adc_cycle_set_a};
			`OFS_CYCLE_SET_B: rd_val = {16'h0, adc_cycle_set_b};
			`OFS_WIDTH_0:     rd_val = {16'h0, pw_width[0]};
			`OFS_WIDTH_1:     rd_val = {16'h0, pw_width[1]};
			`OFS_WIDTH_2:     rd_val = {16'h0, pw_width[2]};
			default:          rd_ok  = 1'b0;
		endcase
	end

	always @* begin
		case (aw_addr)
			`OFS_SYNC_START, `OFS_SYNC_CLEAR, `OFS_FLAGS,
			`OFS_IRQ_ENABLE, `OFS_ADC_CONTROL, `OFS_XFER_ENABLE,
			`OFS_IO_CONTROL, `OFS_CYCLE_SET_A, `OFS_CYCLE_SET_B:
				wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end

	// Current contents of the addressed register, so that byte strobes
	// keep the lanes which a write leaves out.
	always @* begin
		wr_cur = `RST_ZERO32;
		case (aw_addr)
			`OFS_SYNC_START:  wr_cur = {25'h0, companion_start_o,
				counter_start_o};
			`OFS_SYNC_CLEAR:  wr_cur = {24'h0, sync_clear_select};
			`OFS_IRQ_ENABLE:  wr_cur = {4'h0, irq_enable};
			`OFS_ADC_CONTROL: wr_cur = {21'h0, adc_control};
			`OFS_XFER_ENABLE: wr_cur = {3'h0, dma_enable, 4'h0,
				xfer_enable};
			`OFS_IO_CONTROL:  wr_cur = {26'h0, io_control};
			`OFS_CYCLE_SET_A: wr_cur = {16'h0, adc_cycle_set_a};
			`OFS_CYCLE_SET_B: wr_cur = {16'h0, adc_cycle_set_b};
			default:          wr_cur = `RST_ZERO32;
		endcase
	end

	wire [31:0] wr_val = merge(wr_cur, w_data, w_strb);

	// ------------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------------
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			aw_held        <= 1'b0;
			aw_addr        <= 8'h00;
			w_held         <= 1'b0;
			w_data         <= `RST_ZERO32;
			w_strb         <= 4'h0;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= `RESP_OKAY;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rresp_o  <= `RESP_OKAY;
			s_axi_rdata_o  <= `RST_ZERO32;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata_i;
				w_strb <= s_axi_wstrb_i;
			end
			if (do_wr) begin
				aw_held        <= 1'b0;
				w_held         <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
			end
			if (do_rd) begin
				s_axi_rvalid_o <= 1'b1;
				s_axi_rdata_o  <= rd_val;
				s_axi_rresp_o  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_rready_i) begin
				s_axi_rvalid_o <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------------
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			counter_start_o   <= 5'h00;
			companion_start_o <= 2'h0;
			sync_clear_select <= 8'h00;
			irq_enable        <= 28'h0000000;
			adc_control       <= 11'h000;
			xfer_enable       <= 20'h00000;
			dma_enable        <= 5'h00;
			io_control        <= 6'h00;
			adc_cycle_set_a   <= 16'h0000;
			adc_cycle_set_b   <= 16'h0000;
		end else if (do_wr) begin
			case (aw_addr)
				// Both units take their start bits from the same edge, so
				// any companion clock ratio sees one common instant.
				`OFS_SYNC_START: begin
					counter_start_o   <= wr_val[4:0];
					companion_start_o <= wr_val[6:5];
				end
				`OFS_SYNC_CLEAR:  sync_clear_select <= wr_val[7:0];
				`OFS_IRQ_ENABLE:  irq_enable <= wr_val[27:0];
				`OFS_ADC_CONTROL: adc_control <= wr_val[10:0];
				`OFS_XFER_ENABLE: begin
					xfer_enable <= wr_val[19:0];
					dma_enable  <= wr_val[`XFER_DMA_LSB +: 5];
				end
				`OFS_IO_CONTROL:  io_control <= wr_val[5:0];
				`OFS_CYCLE_SET_A: adc_cycle_set_a <= wr_val[15:0];
				`OFS_CYCLE_SET_B: adc_cycle_set_b <= wr_val[15:0];
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Flags, captures and requests
	// ------------------------------------------------------------------
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flags                           <= 28'h0000000;
			flags_read_one                  <= 28'h0000000;
			capture_value                   <= 16'h0000;
			prev_counter                    <= 16'h0000;
			companion_clear_o               <= 1'b0;
			xfer_req_o                      <= 20'h00000;
			dma_req_o                       <= 5'h00;
			common_adc_start_request_o      <= 1'b0;
			ch0_compare_adc_start_request_o <= 1'b0;
			delayed_adc_start_request_a_o   <= 1'b0;
			delayed_adc_start_request_b_o   <= 1'b0;
		end else begin
			flags <= next_flags;
			if (do_rd && (s_axi_araddr_i == `OFS_FLAGS)) begin
				flags_read_one <= (flags_read_one & ~sw_clr) | flags;
			end else begin
				flags_read_one <= flags_read_one & ~sw_clr;
			end
			if (comp_pwm_i && ((io_control[0] && crest_i) ||
				(io_control[1] && trough_i))) begin
				capture_value <= ch4_counter_i;
			end
			prev_counter <= ch4_counter_i;
			companion_clear_o <= |(clr_src & sync_clear_select);
			xfer_req_o <= xsrc_set & xfer_enable;
			dma_req_o  <= dsrc_set & dma_enable;
			common_adc_start_request_o <= (|(first_set &
				adc_control[4:0])) ||
				(trough_hit && adc_control[`ADC_TROUGH_EN]);
			ch0_compare_adc_start_request_o <=
				match_event_i[`FLAG_CH0_FIFTH] &&
				adc_control[`ADC_SECOND_EN];
			// Each output is its own line, so the converter may pick any
			// one of them as its start source.
			delayed_adc_start_request_a_o <= hit_a && en_a;
			delayed_adc_start_request_b_o <= hit_b && en_b;
		end
	end

	// ------------------------------------------------------------------
	// Channel 5 pulse width measurement
	// ------------------------------------------------------------------
	// Measurement runs whether or not complementary PWM is active, so
	// software can time the output delay and correct the duty.
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pw_meta <= 3'h0;
			pw_sync <= 3'h0;
			pw_prev <= 3'h0;
			pw_done <= 3'h0;
			for (i = 0; i < 3; i = i + 1) begin
				pw_count[i] <= 16'h0000;
				pw_width[i] <= 16'h0000;
			end
		end else begin
			pw_meta <= pw_line_i;
			pw_sync <= pw_meta;
			pw_prev <= pw_sync ^ {3{io_control[`IO_PW_LOW]}};
			for (i = 0; i < 3; i = i + 1) begin
				pw_done[i] <= 1'b0;
				if (!io_control[`IO_PW_EN_LSB + i]) begin
					pw_count[i] <= 16'h0000;
				end else if (pw_sync[i] ^ io_control[`IO_PW_LOW]) begin
					if (pw_count[i] != 16'hffff) begin
						pw_count[i] <= pw_count[i] + 16'h0001;
					end
				end else if (pw_prev[i]) begin
					pw_width[i] <= pw_count[i];
					pw_count[i] <= 16'h0000;
					pw_done[i]  <= 1'b1;
				end
			end
		end
	end

endmodule // timer_event_request_logic
`default_nettype wire
